// ==== design/sas_sequencer.sv ====
// adc conversion sequencer with avalon-mm register slave
//
// Behaviour
// - ladder bit 0 connects ladder only while converting, 1 keeps it on
// - time code sets conversion length: 39..1248 fc cycles, 001/111 reserved
// - timing register bits 7 and 6 read 0
// - on completion store result split high/low, set done flag, raise irq
// - done flag reads 0 until completion, cleared by reading high result
// - busy flag set at start, cleared at single mode finish or at stop
// - low result bits 3..0 unimplemented and read 0
// - single mode start write begins one conversion of selected channel
// - start bit clears itself once conversion begins
// - repeat mode stores, flags, interrupts and relaunches each time
// - mode 00 stops at once, partial result discarded
// - new start clears done flag, old result kept until next completion
// - mode field: 00 off, 01 single, 10 reserved, 11 repeat
// - after main control written all zero, starts ignored four cycles
// - start is bit 7; writing 1 requests, writing 0 does nothing
`timescale 1ns/1ns
module sas_sequencer
	import sas_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [7:0] avs_writedata,
	output logic [7:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic comp_in,
	output logic [3:0] channel_sel,
	output logic analog_input_disable,
	output logic ladder_enable,
	output logic sample_hold,
	output logic [9:0] dac_code,
	output logic conv_done_irq
);
	sas_main_s main_ctrl;
	logic [5:0] timing_ctrl;
	sas_result_s result;
	sas_state_e state;
	logic [CONV_CNT_W-1:0] conv_cnt;
	logic [CONV_CNT_W-1:0] conv_len;
	logic [9:0] sar_bit;
	logic [3:0] bit_idx;
	logic [2:0] block_cnt;
	logic comp_q1;
	logic comp_q2;
	logic acc;
	logic wr_main;
	logic rd_high;
	logic start_go;
	logic finish;
	logic stop_now;

	localparam logic [1:0] MODE_RESV = 2'h2;
	localparam logic [9:0] SAR_MID = 10'h200;
	localparam logic [3:0] SAR_TOP_IDX = 4'd9;
	localparam logic [3:0] SAR_END_IDX = 4'hf;
	// three edges per bit: dac settles, then two synchroniser stages
	localparam logic [CONV_CNT_W-1:0] SAR_SPACING = 11'd3;
	localparam logic [CONV_CNT_W-1:0] SAR_TAIL = 11'd2;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs);
		reg_hit = (a == ofs);
	endfunction

	function automatic logic [CONV_CNT_W-1:0] sar_slot(input logic [3:0] b);
		sar_slot = {7'd0, b} * SAR_SPACING + SAR_TAIL;
	endfunction

	function automatic logic [CONV_CNT_W-1:0] conv_cycles(input logic [2:0] c);
		case (c)
			3'h0: conv_cycles = CONV_39;
			3'h2: conv_cycles = CONV_78;
			3'h3: conv_cycles = CONV_156;
			3'h4: conv_cycles = CONV_312;
			3'h5: conv_cycles = CONV_624;
			3'h6: conv_cycles = CONV_1248;
			default: conv_cycles = CONV_1248;
		endcase
	endfunction

	// bus handshake: one wait cycle, answered on the second edge
	assign acc = (avs_read | avs_write) & ~avs_waitrequest;
	assign wr_main = acc & avs_write & reg_hit(avs_address, OFS_MAIN_CTRL);
	assign rd_high = acc & avs_read & reg_hit(avs_address, OFS_RESULT_HIGH);
	assign conv_len = conv_cycles(timing_ctrl[3:1]);
	assign stop_now = (state == SAS_CONV) & (main_ctrl.mode == MODE_OFF);
	assign finish = (state == SAS_CONV) & ~stop_now & (conv_cnt == '0);
	// start taken only when idle, enabled mode and not blocked
	assign start_go = main_ctrl.start & (state == SAS_IDLE) &
		(block_cnt == '0) &
		((main_ctrl.mode == MODE_SINGLE) |
		(main_ctrl.mode == MODE_REPEAT));

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read | avs_write) & avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			avs_readdata <= 8'h00;
		end else if (avs_read & avs_waitrequest) begin
			// loaded in the wait cycle, stands when waitrequest drops
			case (avs_address)
				OFS_MAIN_CTRL: avs_readdata <= main_ctrl;
				OFS_TIMING_CTRL: avs_readdata <= {2'b00, timing_ctrl};
				OFS_RESULT_LOW: avs_readdata <= {result.value[1:0],
					result.done, result.busy, 4'h0};
				OFS_RESULT_HIGH: avs_readdata <= result.value[9:2];
				default: avs_readdata <= 8'h00;
			endcase
		end
	end

	// main control register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			main_ctrl <= MAIN_CTRL_RST;
		end else if (wr_main) begin
			main_ctrl.mode <= avs_writedata[MAIN_MODE_HI:MAIN_MODE_LO];
			main_ctrl.ain_dis <= avs_writedata[MAIN_AIN_DIS_BIT];
			main_ctrl.channel <= avs_writedata[3:0];
			if (avs_writedata[MAIN_START_BIT]) begin
				main_ctrl.start <= 1'b1;
			end
		end else if (start_go | (main_ctrl.start & state == SAS_CONV)) begin
			main_ctrl.start <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			timing_ctrl <= TIMING_CTRL_RST;
		end else if (acc & avs_write & reg_hit(avs_address, OFS_TIMING_CTRL)) begin
			timing_ctrl <= avs_writedata[5:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			block_cnt <= '0;
		end else if (wr_main & (avs_writedata == 8'h00)) begin
			block_cnt <= START_BLOCK_CYC;
		end else if (block_cnt != '0) begin
			block_cnt <= block_cnt - 3'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			comp_q1 <= 1'b0;
			comp_q2 <= 1'b0;
		end else begin
			comp_q1 <= comp_in;
			comp_q2 <= comp_q1;
		end
	end

	// conversion sequencer
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state <= SAS_IDLE;
			conv_cnt <= '0;
		end else if (stop_now) begin
			state <= SAS_IDLE;
		end else if (start_go) begin
			state <= SAS_CONV;
			conv_cnt <= conv_len - 11'd1;
		end else if (finish & main_ctrl.mode == MODE_REPEAT) begin
			conv_cnt <= conv_len - 11'd1;
		end else if (finish) begin
			state <= SAS_IDLE;
		end else if (state == SAS_CONV) begin
			conv_cnt <= conv_cnt - 11'd1;
		end
	end

	// successive approximation: one bit decision every three cycles in the last 30 cycles of the window
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sar_bit <= '0;
			bit_idx <= SAR_TOP_IDX;
			dac_code <= '0;
		end else if (start_go | finish) begin
			sar_bit <= '0;
			bit_idx <= SAR_TOP_IDX;
			dac_code <= SAR_MID;
		end else if (state == SAS_CONV && bit_idx != SAR_END_IDX &&
			conv_cnt == sar_slot(bit_idx)) begin
			sar_bit[bit_idx] <= comp_q2;
			bit_idx <= bit_idx - 4'd1;
			dac_code <= (dac_code & ~(10'h1 << bit_idx) |
				({9'd0, comp_q2} << bit_idx)) |
				((bit_idx != 4'd0) ? (10'h1 << (bit_idx - 4'd1)) : 10'h0);
		end
	end

	// result and flags
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			result <= '0;
			conv_done_irq <= 1'b0;
		end else begin
			conv_done_irq <= finish;
			if (finish) begin
				result.value <= sar_bit;
				result.done <= 1'b1;
			end else if (rd_high | start_go) begin
				result.done <= 1'b0;
			end
			if (start_go) begin
				result.busy <= 1'b1;
			end else if (stop_now | (finish & main_ctrl.mode != MODE_REPEAT)) begin
				result.busy <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			channel_sel <= MAIN_CTRL_RST[3:0];
			analog_input_disable <= MAIN_CTRL_RST[MAIN_AIN_DIS_BIT];
			ladder_enable <= 1'b0;
			sample_hold <= 1'b0;
		end else begin
			channel_sel <= main_ctrl.channel;
			analog_input_disable <= main_ctrl.ain_dis;
			ladder_enable <= timing_ctrl[TIM_LADDER_BIT] |
				(state == SAS_CONV);
			sample_hold <= start_go | finish & main_ctrl.mode == MODE_REPEAT;
		end
	end

	done_on_finish_a: assert property (@(posedge sys_clk) disable iff (srst)
		finish |=> result.done && conv_done_irq)
		else $error("done flag or irq missing after finish");
	done_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
		rd_high && !finish |=> !result.done)
		else $error("done flag not cleared by high read");
	busy_start_a: assert property (@(posedge sys_clk) disable iff (srst)
		start_go |=> result.busy && state == SAS_CONV)
		else $error("busy not set at start");
	start_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
		start_go && !wr_main |=> !main_ctrl.start)
		else $error("start bit did not clear");
	stop_keep_a: assert property (@(posedge sys_clk) disable iff (srst)
		stop_now |=> state == SAS_IDLE && !result.busy &&
		$stable(result.value))
		else $error("stop did not discard conversion");
	block_start_a: assert property (@(posedge sys_clk) disable iff (srst)
		wr_main && avs_writedata == 8'h00 |=> !start_go [*4])
		else $error("start accepted during block window");
	busy_ignore_a: assert property (@(posedge sys_clk) disable iff (srst)
		state == SAS_CONV |-> !start_go)
		else $error("start accepted while busy");
	repeat_go_a: assert property (@(posedge sys_clk) disable iff (srst)
		finish && main_ctrl.mode == MODE_REPEAT |=> state == SAS_CONV &&
		result.busy)
		else $error("repeat did not relaunch");
	time_len_a: assert property (@(posedge sys_clk) disable iff (srst)
		start_go && timing_ctrl[3:1] == 3'h0 |=>
		(state == SAS_CONV && !stop_now && !finish) [*8])
		else $error("conversion ended too early");

	// bus handshake
	wait_one_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest did not drop after one wait");
	wait_back_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	high_data_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		avs_read && avs_waitrequest && !finish &&
		reg_hit(avs_address, OFS_RESULT_HIGH) |=>
		avs_readdata == result.value[9:2])
		else $error("high result read data wrong");
	low_pad_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		avs_read && avs_waitrequest &&
		reg_hit(avs_address, OFS_RESULT_LOW) |=> avs_readdata[3:0] == 4'h0)
		else $error("low result unused bits not zero");
	timing_pad_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		avs_read && avs_waitrequest &&
		reg_hit(avs_address, OFS_TIMING_CTRL) |=> avs_readdata[7:6] == 2'h0)
		else $error("timing register top bits not zero");

	// flags and pulses
	irq_pulse_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		conv_done_irq |=> !conv_done_irq)
		else $error("completion irq longer than one cycle");
	sh_pulse_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		sample_hold |=> !sample_hold)
		else $error("sample pulse longer than one cycle");
	busy_state_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		result.busy == (state == SAS_CONV))
		else $error("busy flag disagrees with sequencer");
	start_done_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		start_go |=> !result.done)
		else $error("done flag kept over new start");
	value_keep_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		!finish |=> $stable(result.value))
		else $error("result changed without completion");
	single_end_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		finish && main_ctrl.mode == MODE_SINGLE |=>
		state == SAS_IDLE && !result.busy)
		else $error("single conversion did not stop");
	dac_mid_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		start_go |=> dac_code == SAR_MID)
		else $error("trial code not at midscale on start");

	// ladder connection
	ladder_on_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		timing_ctrl[TIM_LADDER_BIT] |=> ladder_enable)
		else $error("ladder not held connected");
	ladder_off_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		!timing_ctrl[TIM_LADDER_BIT] && state == SAS_IDLE |=> !ladder_enable)
		else $error("ladder connected while idle");

	// start, mode and stop
	resv_mode_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		main_ctrl.mode == MODE_RESV |-> !start_go)
		else $error("start accepted in reserved mode");
	start_set_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		wr_main && avs_writedata[MAIN_START_BIT] |=> main_ctrl.start)
		else $error("start write not latched");
	start_zero_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		wr_main && !avs_writedata[MAIN_START_BIT] |=>
		main_ctrl.start == $past(main_ctrl.start))
		else $error("zero start write changed start bit");
	mode_stop_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		wr_main && avs_writedata[MAIN_MODE_HI:MAIN_MODE_LO] == MODE_OFF &&
		state == SAS_CONV && !finish |=> stop_now)
		else $error("mode off write did not stop");
	stop_irq_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		stop_now |=> !conv_done_irq)
		else $error("irq raised on stopped conversion");
	block_load_a: assert property (@(posedge sys_clk)
		disable iff (srst)
		wr_main && avs_writedata == 8'h00 |=> block_cnt == START_BLOCK_CYC)
		else $error("start block window not loaded");
endmodule

// ==== pkg/sas_pkg.sv ====
// constants and carrier types for the adc sequencer
package sas_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_MAIN_CTRL = 8'h26;
	localparam logic [7:0] OFS_TIMING_CTRL = 8'h27;
	localparam logic [7:0] OFS_RESULT_LOW = 8'h28;
	localparam logic [7:0] OFS_RESULT_HIGH = 8'h29;
	localparam logic [7:0] MAIN_CTRL_RST = 8'h10;
	localparam logic [5:0] TIMING_CTRL_RST = 6'h10;
	localparam int MAIN_START_BIT = 7;
	localparam int MAIN_MODE_HI = 6;
	localparam int MAIN_MODE_LO = 5;
	localparam int MAIN_AIN_DIS_BIT = 4;
	localparam int TIM_LADDER_BIT = 5;
	localparam int TIM_FIXED1_BIT = 4;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_REPEAT = 2'h3;
	localparam logic [2:0] START_BLOCK_CYC = 3'h4;
	localparam logic [10:0] CONV_39 = 11'd39;
	localparam logic [10:0] CONV_78 = 11'd78;
	localparam logic [10:0] CONV_156 = 11'd156;
	localparam logic [10:0] CONV_312 = 11'd312;
	localparam logic [10:0] CONV_624 = 11'd624;
	localparam logic [10:0] CONV_1248 = 11'd1248;
	localparam int CONV_CNT_W = 11;
	typedef struct packed {
		logic start;
		logic [1:0] mode;
		logic ain_dis;
		logic [3:0] channel;
	} sas_main_s;
	typedef struct packed {
		logic [9:0] value;
		logic done;
		logic busy;
	} sas_result_s;
	typedef enum logic [0:0] {SAS_IDLE, SAS_CONV} sas_state_e;
endpackage

// ==== sim/sas_analog_model.sv ====
// sample-hold, comparator and ladder model for the adc sequencer
`timescale 1ns/1ns
module sas_analog_model (
	input wire logic sys_clk,
	input wire logic [3:0] channel_sel,
	input wire logic [9:0] dac_code,
	input wire logic sample_hold,
	input wire logic ladder_enable,
	output logic comp_in
);
	logic [9:0] held = 10'h000;
	logic tog = 1'b0;
	// held level per channel, toggle stands in for a floating comparator
	always @(posedge sys_clk) begin
		tog <= ~tog;
		if (sample_hold === 1'b1) begin
			held <= 10'h2c9 ^ {channel_sel, 6'h00};
		end
	end
	assign comp_in = ladder_enable ? (held >= dac_code) : tog;
endmodule

// ==== sim/test_sas_sequencer.sv ====
// self-checking bench for the adc sequencer
`timescale 1ns/1ns
module test_sas_sequencer;
	import sas_pkg::*;
	logic sys_clk, srst, avs_read, avs_write, avs_waitrequest, comp_in;
	logic ladder_enable, sample_hold, conv_done_irq, analog_input_disable;
	logic [7:0] avs_address, avs_writedata, avs_readdata, q;
	logic [3:0] channel_sel;
	logic [9:0] dac_code, last;
	int n_mismatch = 0, check_count = 0, cyc = 0, t0 = 0;
	int n_sh = 0, n_irq = 0, sh0, i0;
	logic [2:0] codes[6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
	int lens[6] = '{39, 78, 156, 312, 624, 1248};
	sas_sequencer uut (.sys_clk(sys_clk), .srst(srst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.comp_in(comp_in), .channel_sel(channel_sel),
		.analog_input_disable(analog_input_disable),
		.ladder_enable(ladder_enable), .sample_hold(sample_hold),
		.dac_code(dac_code), .conv_done_irq(conv_done_irq));
	sas_analog_model adc (.sys_clk(sys_clk), .channel_sel(channel_sel),
		.dac_code(dac_code), .sample_hold(sample_hold),
		.ladder_enable(ladder_enable), .comp_in(comp_in));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (sample_hold === 1'b1) n_sh <= n_sh + 1;
		if (conv_done_irq === 1'b1) n_irq <= n_irq + 1;
	end
	task end_sim;
		if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	function logic [9:0] lvl(input logic [3:0] ch);
		return 10'h2c9 ^ {ch, 6'h00};
	endfunction
	task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int k;
		k = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge sys_clk);
			k++;
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
		check(16'(k), 16'h2);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check(q, exp);
	endtask
	task wait_ev(input logic irq, input int lim);
		int k;
		k = 0;
		while ((irq ? conv_done_irq : sample_hold) !== 1'b1 && k < lim) begin
			@(posedge sys_clk);
			k++;
		end
		check(k < lim, 1'b1);
	endtask
	task wait_sh;
		wait_ev(1'b0, 20);
		t0 = cyc;
	endtask
	task wait_irq(input int len);
		wait_ev(1'b1, 1500);
		check(cyc - t0 >= len && cyc - t0 <= len + 6, 1'b1);
		t0 = cyc;
		@(posedge sys_clk);
		check(conv_done_irq, 1'b0);
	endtask
	task conv(input logic [2:0] code, input logic [3:0] ch, input int len);
		bus(1'b1, 8'h27, {4'h1, code, 1'b0});
		rd(8'h27, {4'h1, code, 1'b0});
		bus(1'b1, 8'h26, {4'h2, ch});
		bus(1'b1, 8'h26, {4'ha, ch});
		wait_sh;
		check(channel_sel, ch);
		rd(8'h28, {last[1:0], 6'h10});
		check(ladder_enable, 1'b1);
		rd(8'h29, last[9:2]);
		rd(8'h26, {4'h2, ch});
		bus(1'b1, 8'h26, {4'ha, ch});
		wait_irq(len);
		last = lvl(ch);
		rd(8'h28, {last[1:0], 6'h20});
		rd(8'h29, last[9:2]);
		rd(8'h28, {last[1:0], 6'h00});
		check(ladder_enable, 1'b0);
	endtask
	task t_block;
		bus(1'b1, 8'h26, 8'h00);
		bus(1'b1, 8'h26, 8'ha1);
		@(posedge sys_clk);
		check(sample_hold, 1'b0);
		wait_sh;
		wait_irq(39);
		last = lvl(4'h1);
		rd(8'h28, {last[1:0], 6'h20});
		rd(8'h29, last[9:2]);
	endtask
	initial begin
		srst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 8'h00;
		last = 10'h000;
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		rd(8'h26, MAIN_CTRL_RST);
		rd(8'h27, 8'h10);
		rd(8'h28, 8'h00);
		rd(8'h29, 8'h00);
		rd(8'h3c, 8'h00);
		bus(1'b1, 8'h29, 8'hff);
		rd(8'h29, 8'h00);
		check(analog_input_disable, 1'b1);
		bus(1'b1, 8'h27, 8'h30);
		@(posedge sys_clk);
		check(ladder_enable, 1'b1);
		foreach (codes[i]) conv(codes[i], 4'(i % 4), lens[i]);
		bus(1'b1, 8'h27, 8'h10);
		bus(1'b1, 8'h26, 8'he1);
		wait_sh;
		wait_irq(39);
		wait_irq(39);
		last = lvl(4'h1);
		rd(8'h29, last[9:2]);
		bus(1'b1, 8'h26, 8'h00);
		i0 = n_irq;
		bus(1'b0, 8'h28, 8'h00);
		check({q[7:6], q[4]}, {last[1:0], 1'b0});
		repeat (60) @(posedge sys_clk);
		check(16'(n_irq - i0), 16'h0);
		rd(8'h29, last[9:2]);
		sh0 = n_sh;
		bus(1'b1, 8'h26, 8'hc1);
		bus(1'b1, 8'h26, 8'h81);
		repeat (8) @(posedge sys_clk);
		check(16'(n_sh - sh0), 16'h0);
		t_block;
		end_sim;
	end
	initial begin
		#900000;
		n_mismatch++;
		end_sim;
	end
endmodule
